// ### core/mmps_pkg.sv
// What this block does
// - supply on enters off, no serial traffic
// - any wake pin boots, event low, idle
// - commands accepted only while idle
// - host writes at most twelve payload bytes
// - send frame, event low, back to idle
// - status read returns status, releases event
// - send, wait twenty seconds, listen thirty
// - error code zero makes eight bytes readable
// - off ignores external reset and system reset
// - wake does internal reset, held by reset
// - host holds wake and reset ten microseconds
// - host order: reset, wake pin, release reset
// - boot lasts ten or thirty milliseconds by region
// - idle persists after wake pins drop
// - first boot and send take longer
// - host drops wake pins, then off command
// - host clears pending event before off
// - off refused while any wake pin active
// - send lasts seven or two seconds
// - send/receive command, event twenty to fifty seconds
// - registration key and identifier readable
package mmps_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam longint CLK_HZ = 100_000_000;
	localparam longint MS_CYC = CLK_HZ / 1000;
	localparam longint S_CYC = CLK_HZ;
	localparam int PIN_MIN_NS = 10_000;
	localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOST_TMR_W = 10;
	localparam int BOOT_EU_MS = 10;
	localparam int BOOT_US_MS = 30;
	localparam int INIT_EXTRA_MS = 5;
	localparam int SEND_EU_S = 7;
	localparam int SEND_US_S = 2;
	localparam int RX_WAIT_S = 20;
	localparam int RX_LISTEN_S = 30;
	localparam int SCK_PERIOD_NS = 80;
	localparam int SCK_HALF_CYC = SCK_PERIOD_NS / 2 / CLK_PERIOD_NS;
	localparam logic [7:0] CMD_SYS_RESET = 8'h01;
	localparam logic [7:0] CMD_OFF = 8'h05;
	localparam logic [7:0] CMD_WR_TX = 8'h07;
	localparam logic [7:0] CMD_STATUS = 8'h0A;
	localparam logic [7:0] CMD_SEND = 8'h0D;
	localparam logic [7:0] CMD_SEND_RX = 8'h0E;
	localparam logic [7:0] CMD_PAC = 8'h0F;
	localparam logic [7:0] CMD_RD_RX = 8'h10;
	localparam logic [7:0] CMD_ID = 8'h12;
	localparam int TX_BUF_BYTES = 12;
	localparam int RX_BUF_BYTES = 8;
	localparam int PAC_BYTES = 16;
	localparam int ID_BYTES = 4;
	localparam logic [3:0] ERR_OK = 4'h0;
	localparam logic [3:0] ERR_NO_DOWNLINK = 4'h1;
	localparam logic [5:0] WAKE_LOW_OFF = 6'h3F;
	typedef enum logic [2:0] {
		D_OFF = 3'b000,
		D_WAKE = 3'b001,
		D_BOOT = 3'b011,
		D_IDLE = 3'b010,
		D_SEND = 3'b110,
		D_WAIT = 3'b111,
		D_LISTEN = 3'b101
	} mmps_dstate_t;
	typedef enum logic [2:0] {
		H_OFF = 3'b000,
		H_RST = 3'b001,
		H_PIN = 3'b011,
		H_ON = 3'b010,
		H_FRM = 3'b110
	} mmps_hstate_t;
endpackage : mmps_pkg

// ### core/mmps_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mmps_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic wake_pin_high;
	logic [5:0] wake_pin_low_set;
	logic external_reset_low;
	logic event_line_n;
	modport dev (
		input sck, cs_n, mosi, wake_pin_high, wake_pin_low_set, external_reset_low,
		output miso, miso_oe, event_line_n
	);
	modport host (
		output sck, cs_n, mosi, wake_pin_high, wake_pin_low_set, external_reset_low,
		input miso, miso_oe, event_line_n
	);
endinterface : mmps_if
`default_nettype wire

// ### core/mmps_device.sv
`timescale 1ns/1ps
`default_nettype none
module mmps_device #(
	parameter logic [32:0] BOOT_EU_CYC = 33'(mmps_pkg::BOOT_EU_MS * mmps_pkg::MS_CYC),
	parameter logic [32:0] BOOT_US_CYC = 33'(mmps_pkg::BOOT_US_MS * mmps_pkg::MS_CYC),
	parameter logic [32:0] INIT_CYC = 33'(mmps_pkg::INIT_EXTRA_MS * mmps_pkg::MS_CYC),
	parameter logic [32:0] SEND_EU_CYC = 33'(mmps_pkg::SEND_EU_S * mmps_pkg::S_CYC),
	parameter logic [32:0] SEND_US_CYC = 33'(mmps_pkg::SEND_US_S * mmps_pkg::S_CYC),
	parameter logic [32:0] RX_WAIT_CYC = 33'(mmps_pkg::RX_WAIT_S * mmps_pkg::S_CYC),
	parameter logic [32:0] RX_LISTEN_CYC = 33'(mmps_pkg::RX_LISTEN_S * mmps_pkg::S_CYC),
	// identity values are arbitrary
	parameter logic [127:0] PAC_VAL = 128'h1122_3344_5566_7788_99aa_bbcc_ddee_ff00,
	parameter logic [31:0] ID_VAL = 32'h1357_9bdf
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic arst_n,
	// link to host
	mmps_if.dev lnk,
	// radio side
	input wire logic region_eu,
	input wire logic dl_valid,
	input wire logic [3:0] dl_err,
	input wire logic [63:0] dl_data,
	output logic awake,
	output logic tx_on,
	output logic rx_on,
	output logic [3:0] tx_len,
	output logic [95:0] tx_payload
);
	mmps_pkg::mmps_dstate_t state_q, st_d;
	logic [10:0] sy1_q;
	logic [10:0] sy2_q;
	logic sck_p_q;
	logic cs_p_q;
	logic [32:0] tmr_q, tmr_d;
	logic evt_q, evt_set, evt_clr;
	logic txd_q, txd_d;
	logic rxd_q, rxd_d;
	logic rxm_q, rxm_d;
	logic fb_q, fb_d;
	logic fs_q, fs_d;
	logic [3:0] err_q, err_d;
	logic [3:0] len_q, len_d;
	logic rx_cap;
	logic [2:0] bit_cnt_q;
	logic [7:0] rx_sh_q;
	logic [4:0] byte_idx_q;
	logic [7:0] cmd_q;
	logic [7:0] out_sh_q;
	logic [7:0] tx_buf_q [mmps_pkg::TX_BUF_BYTES];
	logic [7:0] rx_buf_q [mmps_pkg::RX_BUF_BYTES];
	// idle pin levels, so leaving reset shows no false wake or clock edge
	localparam logic [10:0] PINS_IDLE = {1'b1, mmps_pkg::WAKE_LOW_OFF, 1'b0, 1'b0, 1'b1, 1'b0};

	// pins pass two flops; nothing reads the first stage
	wire logic [10:0] pins = {lnk.external_reset_low, lnk.wake_pin_low_set, lnk.wake_pin_high,
		lnk.mosi, lnk.cs_n, lnk.sck};
	wire logic s_sck = sy2_q[0];
	wire logic s_csn = sy2_q[1];
	wire logic s_mosi = sy2_q[2];
	wire logic wake_any = sy2_q[3] | ~&sy2_q[9:4];
	wire logic rst_act = ~sy2_q[10];
	wire logic sck_rise = s_sck & ~sck_p_q;
	wire logic sck_fall = ~s_sck & sck_p_q;
	wire logic cs_act = ~s_csn;
	wire logic cs_end = s_csn & ~cs_p_q;
	wire logic link_on = state_q == mmps_pkg::D_IDLE;
	wire logic take_bit = link_on & cs_act & sck_rise;
	wire logic byte_done = take_bit & (&bit_cnt_q);
	wire logic [7:0] new_byte = {rx_sh_q[6:0], s_mosi};
	wire logic [7:0] cmd_eff = (byte_idx_q == '0) ? new_byte : cmd_q;
	wire logic exec = link_on & cs_end & (byte_idx_q != '0);
	wire logic [4:0] r = byte_idx_q;
	wire logic wr_slot = (r != '0) && (r <= 5'(mmps_pkg::TX_BUF_BYTES));
	wire logic [3:0] wr_idx = 4'(r - 5'd1);
	wire logic [7:0] status_byte = {1'b0, region_eu, rxd_q, txd_q, err_q};
	wire logic [7:0] rx_byte = (r < 5'(mmps_pkg::RX_BUF_BYTES) && err_q == mmps_pkg::ERR_OK)
		? rx_buf_q[r[2:0]] : 8'h00;
	wire logic [7:0] pac_byte = (r < 5'(mmps_pkg::PAC_BYTES))
		? PAC_VAL[8 * (mmps_pkg::PAC_BYTES - 1 - int'(r)) +: 8] : 8'h00;
	wire logic [7:0] id_byte = (r < 5'(mmps_pkg::ID_BYTES))
		? ID_VAL[8 * (mmps_pkg::ID_BYTES - 1 - int'(r)) +: 8] : 8'h00;
	wire logic [7:0] resp =
		(cmd_eff == mmps_pkg::CMD_STATUS && r == '0) ? status_byte :
		(cmd_eff == mmps_pkg::CMD_RD_RX) ? rx_byte :
		(cmd_eff == mmps_pkg::CMD_PAC) ? pac_byte :
		(cmd_eff == mmps_pkg::CMD_ID) ? id_byte : 8'h00;
	wire logic tmr_zero = tmr_q == '0;
	wire logic [32:0] boot_cyc = (region_eu ? BOOT_EU_CYC : BOOT_US_CYC) + (fb_q ? INIT_CYC : '0);
	wire logic [32:0] send_cyc = (region_eu ? SEND_EU_CYC : SEND_US_CYC) + (fs_q ? INIT_CYC : '0);

	assign lnk.miso = out_sh_q[7];
	assign lnk.miso_oe = link_on & cs_act;
	assign lnk.event_line_n = ~evt_q;
	assign awake = state_q != mmps_pkg::D_OFF;
	assign tx_on = state_q == mmps_pkg::D_SEND;
	assign rx_on = state_q == mmps_pkg::D_LISTEN;
	assign tx_len = len_q;
	for (genvar i = 0; i < mmps_pkg::TX_BUF_BYTES; i++) begin : g_pay
		assign tx_payload[95 - 8 * i -: 8] = tx_buf_q[i];
	end

	always_comb begin
		st_d = state_q;
		tmr_d = tmr_zero ? tmr_q : tmr_q - 33'd1;
		evt_set = 1'b0;
		evt_clr = 1'b0;
		txd_d = txd_q;
		rxd_d = rxd_q;
		rxm_d = rxm_q;
		fb_d = fb_q;
		fs_d = fs_q;
		err_d = err_q;
		len_d = len_q;
		rx_cap = 1'b0;
		unique case (state_q)
			mmps_pkg::D_OFF: begin
				if (wake_any) begin
					st_d = mmps_pkg::D_WAKE;
				end
			end
			mmps_pkg::D_WAKE: begin
				txd_d = 1'b0;
				rxd_d = 1'b0;
				err_d = mmps_pkg::ERR_OK;
				len_d = '0;
				if (!rst_act) begin
					st_d = mmps_pkg::D_BOOT;
					tmr_d = boot_cyc;
				end
			end
			mmps_pkg::D_BOOT: begin
				if (tmr_zero) begin
					st_d = mmps_pkg::D_IDLE;
					evt_set = 1'b1;
					fb_d = 1'b0;
				end
			end
			mmps_pkg::D_IDLE: begin
				if (exec) begin
					unique case (cmd_q)
						mmps_pkg::CMD_SEND, mmps_pkg::CMD_SEND_RX: begin
							st_d = mmps_pkg::D_SEND;
							tmr_d = send_cyc;
							rxm_d = cmd_q == mmps_pkg::CMD_SEND_RX;
							txd_d = 1'b0;
							rxd_d = 1'b0;
						end
						mmps_pkg::CMD_STATUS: evt_clr = 1'b1;
						mmps_pkg::CMD_OFF: begin
							if (!wake_any) begin
								st_d = mmps_pkg::D_OFF;
							end
						end
						mmps_pkg::CMD_SYS_RESET: st_d = mmps_pkg::D_WAKE;
						mmps_pkg::CMD_WR_TX: begin
							len_d = (r > 5'(mmps_pkg::TX_BUF_BYTES))
								? 4'(mmps_pkg::TX_BUF_BYTES) : wr_idx;
						end
						default: ;
					endcase
				end
			end
			mmps_pkg::D_SEND: begin
				if (tmr_zero) begin
					fs_d = 1'b0;
					txd_d = 1'b1;
					if (rxm_q) begin
						st_d = mmps_pkg::D_WAIT;
						tmr_d = RX_WAIT_CYC;
					end else begin
						st_d = mmps_pkg::D_IDLE;
						evt_set = 1'b1;
					end
				end
			end
			mmps_pkg::D_WAIT: begin
				if (tmr_zero) begin
					st_d = mmps_pkg::D_LISTEN;
					tmr_d = RX_LISTEN_CYC;
				end
			end
			mmps_pkg::D_LISTEN: begin
				if (dl_valid || tmr_zero) begin
					st_d = mmps_pkg::D_IDLE;
					evt_set = 1'b1;
					rxd_d = 1'b1;
					rx_cap = dl_valid;
					err_d = dl_valid ? dl_err : mmps_pkg::ERR_NO_DOWNLINK;
				end
			end
			default: st_d = mmps_pkg::D_OFF;
		endcase
		if (rst_act && state_q != mmps_pkg::D_OFF) begin
			st_d = mmps_pkg::D_WAKE;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= mmps_pkg::D_OFF;
			tmr_q <= '0;
			evt_q <= 1'b0;
			txd_q <= 1'b0;
			rxd_q <= 1'b0;
			rxm_q <= 1'b0;
			fb_q <= 1'b1;
			fs_q <= 1'b1;
			err_q <= mmps_pkg::ERR_OK;
			len_q <= '0;
		end else begin
			state_q <= st_d;
			tmr_q <= tmr_d;
			evt_q <= evt_set | (evt_q & ~evt_clr);
			txd_q <= txd_d;
			rxd_q <= rxd_d;
			rxm_q <= rxm_d;
			fb_q <= fb_d;
			fs_q <= fs_d;
			err_q <= err_d;
			len_q <= len_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sy1_q <= PINS_IDLE;
			sy2_q <= PINS_IDLE;
			sck_p_q <= 1'b0;
			cs_p_q <= 1'b1;
		end else begin
			sy1_q <= pins;
			sy2_q <= sy1_q;
			sck_p_q <= s_sck;
			cs_p_q <= s_csn;
		end
	end

	// frame engine: sample on rise, shift out on fall, reload after each byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_q <= '0;
			rx_sh_q <= '0;
			byte_idx_q <= '0;
			cmd_q <= '0;
			out_sh_q <= '0;
		end else if (!cs_act || !link_on) begin
			bit_cnt_q <= '0;
			byte_idx_q <= '0;
			out_sh_q <= '0;
		end else if (take_bit) begin
			rx_sh_q <= new_byte;
			bit_cnt_q <= bit_cnt_q + 3'd1;
			if (byte_done) begin
				byte_idx_q <= (&byte_idx_q) ? byte_idx_q : byte_idx_q + 5'd1;
				cmd_q <= cmd_eff;
				out_sh_q <= resp;
			end
		end else if (sck_fall && bit_cnt_q != '0) begin
			out_sh_q <= {out_sh_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (byte_done && cmd_eff == mmps_pkg::CMD_WR_TX && wr_slot) begin
			tx_buf_q[wr_idx] <= new_byte;
		end
		if (rx_cap) begin
			for (int i = 0; i < mmps_pkg::RX_BUF_BYTES; i++) begin
				rx_buf_q[i] <= dl_data[63 - 8 * i -: 8];
			end
		end
	end
endmodule : mmps_device
`default_nettype wire

// ### core/mmps_host.sv
`timescale 1ns/1ps
`default_nettype none
module mmps_host (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link to device
	mmps_if.host lnk,
	// user side
	input wire logic pwr_on_req,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_code,
	input wire logic [3:0] cmd_wr_len,
	input wire logic [95:0] cmd_wr_data,
	input wire logic [4:0] cmd_rd_len,
	output logic rsp_valid,
	output logic [127:0] rsp_data,
	output logic event_pending,
	output logic powered
);
	localparam int TW = mmps_pkg::HOST_TMR_W;
	localparam logic [TW-1:0] HALF_T = TW'(mmps_pkg::SCK_HALF_CYC - 1);
	localparam logic [TW-1:0] GAP_T = TW'(2 * mmps_pkg::SCK_HALF_CYC - 1);
	localparam logic [TW-1:0] PIN_T = TW'(mmps_pkg::PIN_MIN_CYC - 1);
	typedef enum logic [1:0] {
		F_LEAD = 2'b00,
		F_BITS = 2'b01,
		F_TAIL = 2'b11,
		F_GAP = 2'b10
	} mmps_fph_t;
	mmps_pkg::mmps_hstate_t st_q, st_d;
	mmps_fph_t ph_q, ph_d;
	logic [TW-1:0] tmr_q, tmr_d;
	logic sck_q, sck_d;
	logic csn_q, csn_d;
	logic wake_q, wake_d;
	logic rstn_q, rstn_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] in_q, in_d;
	logic [2:0] bit_q, bit_d;
	logic [4:0] cnt_q, cnt_d;
	logic first_q, first_d;
	logic [7:0] code_q, code_d;
	logic [95:0] data_q, data_d;
	logic [127:0] acc_q, acc_d;
	logic done_q, done_d;
	logic [1:0] miso_sy_q;
	logic [1:0] evt_sy_q;
	logic evt_q;

	wire logic miso_s = miso_sy_q[1];
	wire logic tmr_zero = tmr_q == '0;
	wire logic take = cmd_valid & cmd_ready;
	wire logic is_wr = cmd_code == mmps_pkg::CMD_WR_TX;
	// never more than twelve payload bytes
	wire logic [4:0] wr_n = (cmd_wr_len > 4'(mmps_pkg::TX_BUF_BYTES))
		? 5'(mmps_pkg::TX_BUF_BYTES) : {1'b0, cmd_wr_len};
	wire logic [4:0] rd_n = (cmd_rd_len > 5'(mmps_pkg::PAC_BYTES))
		? 5'(mmps_pkg::PAC_BYTES) : cmd_rd_len;
	// miso is sampled at the end of the high half, well after the device shifted
	wire logic [7:0] got = {in_q[6:0], miso_s};
	wire logic [7:0] next_byte = (code_q == mmps_pkg::CMD_WR_TX) ? data_q[95:88] : 8'h00;

	assign lnk.sck = sck_q;
	assign lnk.cs_n = csn_q;
	assign lnk.mosi = sh_q[7];
	assign lnk.wake_pin_high = wake_q;
	assign lnk.wake_pin_low_set = mmps_pkg::WAKE_LOW_OFF ^ {5'b0_0000, wake_q};
	assign lnk.external_reset_low = rstn_q;
	assign cmd_ready = st_q == mmps_pkg::H_ON;
	assign rsp_valid = done_q;
	assign rsp_data = acc_q;
	assign event_pending = evt_q;
	assign powered = (st_q == mmps_pkg::H_ON) || (st_q == mmps_pkg::H_FRM);

	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		tmr_d = tmr_zero ? tmr_q : tmr_q - TW'(1);
		sck_d = sck_q;
		csn_d = csn_q;
		wake_d = wake_q;
		rstn_d = rstn_q;
		sh_d = sh_q;
		in_d = in_q;
		bit_d = bit_q;
		cnt_d = cnt_q;
		first_d = first_q;
		code_d = code_q;
		data_d = data_q;
		acc_d = acc_q;
		done_d = 1'b0;
		unique case (st_q)
			mmps_pkg::H_OFF: begin
				// reset goes active before any wake pin
				if (pwr_on_req) begin
					st_d = mmps_pkg::H_RST;
					rstn_d = 1'b0;
					tmr_d = PIN_T;
				end
			end
			mmps_pkg::H_RST: begin
				// each pin held the full minimum
				if (tmr_zero) begin
					st_d = mmps_pkg::H_PIN;
					wake_d = 1'b1;
					tmr_d = PIN_T;
				end
			end
			mmps_pkg::H_PIN: begin
				if (tmr_zero) begin
					st_d = mmps_pkg::H_ON;
					rstn_d = 1'b1;
				end
			end
			mmps_pkg::H_ON: begin
				// wake pins drop with the request, never raised again here
				wake_d = wake_q & pwr_on_req;
				if (take) begin
					st_d = mmps_pkg::H_FRM;
					ph_d = F_LEAD;
					tmr_d = HALF_T;
					csn_d = 1'b0;
					sh_d = cmd_code;
					bit_d = '0;
					cnt_d = is_wr ? wr_n : rd_n;
					first_d = 1'b1;
					code_d = cmd_code;
					data_d = cmd_wr_data;
					acc_d = '0;
				end
			end
			mmps_pkg::H_FRM: begin
				wake_d = wake_q & pwr_on_req;
				if (tmr_zero) begin
					tmr_d = HALF_T;
					unique case (ph_q)
						F_LEAD: begin
							ph_d = F_BITS;
							sck_d = 1'b1;
						end
						F_BITS: begin
							sck_d = ~sck_q;
							if (sck_q) begin
								in_d = got;
								bit_d = bit_q + 3'd1;
								sh_d = {sh_q[6:0], 1'b0};
								if (&bit_q) begin
									first_d = 1'b0;
									if (!first_q) begin
										acc_d = {acc_q[119:0], got};
									end
									if (cnt_q == '0) begin
										ph_d = F_TAIL;
									end else begin
										cnt_d = cnt_q - 5'd1;
										sh_d = next_byte;
										data_d = {data_q[87:0], 8'h00};
									end
								end
							end
						end
						F_TAIL: begin
							ph_d = F_GAP;
							csn_d = 1'b1;
							tmr_d = GAP_T;
						end
						F_GAP: begin
							// gap lets the device act on the frame before the answer is given
							done_d = 1'b1;
							st_d = (code_q == mmps_pkg::CMD_OFF && !wake_q)
								? mmps_pkg::H_OFF : mmps_pkg::H_ON;
						end
					endcase
				end
			end
			default: st_d = mmps_pkg::H_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= mmps_pkg::H_OFF;
			ph_q <= F_LEAD;
			tmr_q <= '0;
			sck_q <= 1'b0;
			csn_q <= 1'b1;
			wake_q <= 1'b0;
			rstn_q <= 1'b1;
			sh_q <= '0;
			in_q <= '0;
			bit_q <= '0;
			cnt_q <= '0;
			first_q <= 1'b1;
			code_q <= '0;
			data_q <= '0;
			acc_q <= '0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			tmr_q <= tmr_d;
			sck_q <= sck_d;
			csn_q <= csn_d;
			wake_q <= wake_d;
			rstn_q <= rstn_d;
			sh_q <= sh_d;
			in_q <= in_d;
			bit_q <= bit_d;
			cnt_q <= cnt_d;
			first_q <= first_d;
			code_q <= code_d;
			data_q <= data_d;
			acc_q <= acc_d;
			done_q <= done_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			miso_sy_q <= '0;
			evt_sy_q <= '1;
			evt_q <= 1'b0;
		end else begin
			miso_sy_q <= {miso_sy_q[0], lnk.miso};
			evt_sy_q <= {evt_sy_q[0], lnk.event_line_n};
			evt_q <= ~evt_sy_q[1];
		end
	end
endmodule : mmps_host
`default_nettype wire

// ### tb/mmps_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mmps_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link signals
	input wire logic sck,
	input wire logic cs_n,
	input wire logic miso_oe,
	input wire logic wake_pin_high,
	input wire logic [5:0] wake_pin_low_set,
	input wire logic external_reset_low,
	input wire logic event_line_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [15:0] rst_cnt_q;
	logic [7:0] since_cs_q;
	wire logic wake_on = wake_pin_high || (wake_pin_low_set != mmps_pkg::WAKE_LOW_OFF);
	wire logic [15:0] rst_cnt_d = external_reset_low ? 16'h0 : rst_cnt_q + 16'h1;
	// saturates so a long idle gap never wraps back into the window
	wire logic [7:0] since_cs_d = !cs_n ? 8'h0 : (&since_cs_q ? since_cs_q : since_cs_q + 8'h1);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_cnt_q <= 16'h0;
			since_cs_q <= 8'hff;
		end else begin
			rst_cnt_q <= rst_cnt_d;
			since_cs_q <= since_cs_d;
		end
	end
	chk_miso_when_selected: assert property (miso_oe |-> !$past(cs_n, 2))
		else $error("miso driven while deselected");
	chk_sck_idle_still: assert property ($past(cs_n) && cs_n |-> $stable(sck))
		else $error("link clock moved outside a frame");
	chk_reset_min_hold: assert property ($rose(external_reset_low) |->
		rst_cnt_q >= 16'(mmps_pkg::PIN_MIN_CYC - 1))
		else $error("external reset pulse too short");
	chk_wake_after_reset: assert property ($rose(wake_on) |-> !external_reset_low)
		else $error("wake pin raised before reset");
	chk_release_with_wake: assert property ($rose(external_reset_low) |-> wake_on)
		else $error("reset released without wake pin");
	chk_reset_holds_boot: assert property (!external_reset_low |-> event_line_n)
		else $error("event raised while held in reset");
	chk_event_stays_low: assert property ($fell(event_line_n) |=> !event_line_n [*4])
		else $error("event released too early");
	chk_event_clear_frame: assert property ($rose(event_line_n) |-> since_cs_q < 8'h10)
		else $error("event released without a status frame");
	cover property ($rose(wake_on));
	cover property ($fell(event_line_n));
	cover property ($rose(event_line_n));
endmodule : mmps_asserts
`default_nettype wire

// ### tb/mmps_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module mmps_test;
	typedef struct {logic [7:0] code; logic [4:0] rl; logic [127:0] exp;} mmps_row_t;
	// identity values are arbitrary
	localparam logic [31:0] ID_V = 32'h2468_ace0;
	localparam logic [127:0] PAC_V = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
	localparam logic [95:0] PAY = 96'ha1a2_a3a4_b1b2_b3b4_c1c2_c3c4;
	localparam logic [63:0] DL = 64'h5a5a_0123_4567_89ab;
	mmps_row_t rows [2] = '{'{mmps_pkg::CMD_ID, 5'h4, 128'(ID_V)},
		'{mmps_pkg::CMD_PAC, 5'h10, PAC_V}};
	logic clk = 0, arst_n = 0, pwr_on_req = 0, cmd_valid = 0, region_eu = 1, dl_valid = 0;
	logic cmd_ready, rsp_valid, event_pending, powered, awake, tx_on, rx_on;
	logic [7:0] cmd_code = 0;
	logic [3:0] cmd_wr_len = 0, dl_err = 0, tx_len;
	logic [95:0] cmd_wr_data = 0, tx_payload;
	logic [4:0] cmd_rd_len = 0;
	logic [127:0] rsp_data, rsp_q;
	logic [63:0] dl_data = 0;
	int num_errors = 0, checks_done = 0;
	mmps_if lnk_if();
	mmps_device #(.BOOT_EU_CYC(33'h7d0), .BOOT_US_CYC(33'hbb8), .INIT_CYC(33'h1f4),
		.SEND_EU_CYC(33'hfa0), .SEND_US_CYC(33'h9c4), .RX_WAIT_CYC(33'h7d0),
		.RX_LISTEN_CYC(33'hbb8), .PAC_VAL(PAC_V), .ID_VAL(ID_V)) mmps_device_i (
		.clk(clk), .arst_n(arst_n), .lnk(lnk_if), .region_eu(region_eu),
		.dl_valid(dl_valid), .dl_err(dl_err), .dl_data(dl_data), .awake(awake),
		.tx_on(tx_on), .rx_on(rx_on), .tx_len(tx_len), .tx_payload(tx_payload));
	mmps_host mmps_host_i (.clk(clk), .arst_n(arst_n), .lnk(lnk_if), .pwr_on_req(pwr_on_req),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
		.cmd_wr_len(cmd_wr_len), .cmd_wr_data(cmd_wr_data), .cmd_rd_len(cmd_rd_len),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .event_pending(event_pending),
		.powered(powered));
	mmps_asserts mmps_asserts_i (.clk(clk), .arst_n(arst_n), .sck(lnk_if.sck),
		.cs_n(lnk_if.cs_n), .miso_oe(lnk_if.miso_oe), .wake_pin_high(lnk_if.wake_pin_high),
		.wake_pin_low_set(lnk_if.wake_pin_low_set),
		.external_reset_low(lnk_if.external_reset_low), .event_line_n(lnk_if.event_line_n));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic wt(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask : wt
	task automatic cmd(input logic [7:0] c, input logic [3:0] wl, input logic [4:0] rl,
		input logic [95:0] d = PAY);
		cmd_code <= c;
		cmd_wr_len <= wl;
		cmd_wr_data <= d;
		cmd_rd_len <= rl;
		cmd_valid <= 1'b1;
		@(posedge clk);
		wt(cmd_ready, 5000);
		cmd_valid <= 1'b0;
		wt(rsp_valid, 3000);
		rsp_q = rsp_data;
		@(posedge clk);
	endtask : cmd
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	initial begin
		#900_000;
		num_errors++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		`CHK("awake off", 1'b0, awake)
		pwr_on_req <= 1'b1;
		wt(event_pending, 20000);
		`CHK("awake boot", 1'b1, awake)
		`CHK("boot event", 1'b1, event_pending)
		`CHK("powered", 1'b1, powered)
		cmd(mmps_pkg::CMD_STATUS, 4'h0, 5'h1);
		repeat (4) @(posedge clk);
		`CHK("event clear", 1'b0, event_pending)
		$display("test boot done");
		foreach (rows[i]) begin
			cmd(rows[i].code, 4'h0, rows[i].rl);
			`CHK("ident", rows[i].exp, rsp_q & ((128'h1 << (rows[i].rl * 8)) - 1))
		end
		$display("test ident done");
		cmd(mmps_pkg::CMD_WR_TX, 4'hc, 5'h0);
		`CHK("tx len", 4'hc, tx_len)
		`CHK("tx payload", PAY, tx_payload)
		cmd(mmps_pkg::CMD_SEND, 4'h0, 5'h0);
		`CHK("tx on", 1'b1, tx_on)
		wt(event_pending, 20000);
		`CHK("send done", 2'b01, {tx_on, awake})
		cmd(mmps_pkg::CMD_STATUS, 4'h0, 5'h1);
		$display("test send done");
		cmd(mmps_pkg::CMD_SEND_RX, 4'h0, 5'h0);
		wt(rx_on, 20000);
		`CHK("listen", 2'b10, {rx_on, event_pending})
		dl_data <= DL;
		dl_err <= mmps_pkg::ERR_OK;
		dl_valid <= 1'b1;
		@(posedge clk);
		dl_valid <= 1'b0;
		wt(event_pending, 20000);
		`CHK("rx event", 1'b1, event_pending)
		cmd(mmps_pkg::CMD_STATUS, 4'h0, 5'h1);
		cmd(mmps_pkg::CMD_RD_RX, 4'h0, 5'h8);
		`CHK("rx data", DL, rsp_q[63:0])
		$display("test send receive done");
		`CHK("no event at off", 1'b0, event_pending)
		cmd(mmps_pkg::CMD_OFF, 4'h0, 5'h0);
		repeat (100) @(posedge clk);
		`CHK("off refused", 1'b1, awake)
		pwr_on_req <= 1'b0;
		repeat (2000) @(posedge clk);
		`CHK("idle kept", 1'b1, awake)
		cmd(mmps_pkg::CMD_OFF, 4'h0, 5'h0);
		repeat (100) @(posedge clk);
		`CHK("off taken", 1'b0, awake)
		`CHK("host off", 1'b0, powered)
		$display("test shutdown done");
		region_eu <= 1'b0;
		pwr_on_req <= 1'b1;
		wt(event_pending, 20000);
		`CHK("us boot", 2'b11, {awake, powered})
		cmd(mmps_pkg::CMD_STATUS, 4'h0, 5'h1);
		cmd(mmps_pkg::CMD_WR_TX, 4'hf, 5'h0, ~PAY);
		`CHK("tx len cap", 4'hc, tx_len)
		`CHK("tx payload 2", ~PAY, tx_payload)
		cmd(mmps_pkg::CMD_SEND_RX, 4'h0, 5'h0);
		wt(rx_on, 20000);
		dl_data <= ~DL;
		dl_err <= mmps_pkg::ERR_NO_DOWNLINK;
		dl_valid <= 1'b1;
		@(posedge clk);
		dl_valid <= 1'b0;
		wt(event_pending, 20000);
		`CHK("rx err event", 1'b1, event_pending)
		cmd(mmps_pkg::CMD_STATUS, 4'h0, 5'h1);
		cmd(mmps_pkg::CMD_RD_RX, 4'h0, 5'h8);
		`CHK("rx data blocked", 64'h0, rsp_q[63:0])
		$display("test us mode done");
		close_out();
	end
endmodule : mmps_test
`default_nettype wire
